// ===== src/reset_supervisor_regs.svh
// timing constants, widths and pin positions for the reset supervisor
//-----------------------------------------------------------------------
// Operation
// [R1] reset held low while converter disabled
// [R2] wait release hold time after faults end
// [R3] filtered undervoltage fault with hysteresis clear
// [R4] filtered overvoltage fault with hysteresis clear
// [R5] overvoltage stops switching, weak switch pulldown
// [R6] thermal fault from trip until recovery
// [R7] enable low faults until turn-on delay
// [R8] internal supply lockout fault with hysteresis
// [R9] soft start holds reset until target/limit
// [R10] soft-start-only lockout releases without hold time
// [R11] reset works down to minimum input
// [R12] partner drives enable low for shutdown
// [R13] release hold time nominally 2.1 ms
// [R14] deglitch filter nominally 26 us
// [R15] turn-on delay nominally 0.82 ms
// [R16] open-drain pulldown enable from faults/timer
//-----------------------------------------------------------------------
`ifndef RESET_SUPERVISOR_REGS_SVH
`define RESET_SUPERVISOR_REGS_SVH

// clock and timing figures in nanoseconds
`define CLK_PERIOD_NS        25
`define FILTER_TIME_NS       26000
`define RELEASE_HOLD_TIME_NS 2100000
`define TURN_ON_DELAY_NS     820000
`define SS_LIMIT_TIME_NS     3000000
// least time rounded up to whole cycles
`define NS_TO_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// counter widths
`define CNT_W  18
`define FILT_W 11

// synchronised pin positions
`define SYNC_W        11
`define PIN_FB_UV     0
`define PIN_FB_UV_OK  1
`define PIN_FB_OV     2
`define PIN_FB_OV_OK  3
`define PIN_TEMP_TRIP 4
`define PIN_TEMP_OK   5
`define PIN_ENABLE    6
`define PIN_VCC_LOW   7
`define PIN_VCC_OK    8
`define PIN_TARGET    9
`define PIN_VIN_OK    10

`endif

// ===== src/reset_supervisor_pkg.sv
// types shared by the reset supervisor modules
package reset_supervisor_pkg;
`include "reset_supervisor_regs.svh"

  // release sequencing states
  typedef enum logic [3:0] {
    ST_FAULT = 4'h1,
    ST_HOLD  = 4'h2,
    ST_LOCK  = 4'h4,
    ST_OPEN  = 4'h8
  } supervise_e;

  // deglitch filter state
  typedef struct packed {
    logic [`FILT_W-1:0] cnt;
    logic               flag;
  } filter_s;

  // supervisor state
  typedef struct packed {
    logic [`SYNC_W-1:0] meta;
    logic [`SYNC_W-1:0] sync;
    logic               thermal;
    logic               vccFault;
    logic               enFault;
    logic [`CNT_W-1:0]  onCnt;
    logic               holdActive;
    logic [`CNT_W-1:0]  holdCnt;
    logic               ssActive;
    logic [`CNT_W-1:0]  ssCnt;
    supervise_e         state;
    logic               resetOe;
    logic               resetOut;
    logic               switchStop;
    logic               switchPulldown;
  } monitor_s;

endpackage : reset_supervisor_pkg

// ===== src/threshold_deglitch.sv
// deglitch filter with separate set and clear conditions
`timescale 1ns/100ps
`include "reset_supervisor_regs.svh"
module threshold_deglitch
  import reset_supervisor_pkg::*;
#(
  parameter logic [`FILT_W-1:0] FILT_CYC =
    `FILT_W'(`NS_TO_CYC(`FILTER_TIME_NS))
) (
  input  wire logic sys_clk,   // system clock
  input  wire logic rst_n,     // sync reset, active low
  input  wire logic setCond,   // condition that raises the flag
  input  wire logic clearCond, // condition that lowers the flag
  output logic      flag       // filtered fault flag
);

  filter_s st;
  filter_s next_st;

  //-----------------------------------------------------------------
  // filter
  //-----------------------------------------------------------------
  // condition must hold longer than the filter time
  // [R14] filter time count
  always_comb begin
    next_st = st;
    if (!st.flag) begin
      if (!setCond) begin
        next_st.cnt = '0;
      end else if (st.cnt == FILT_CYC) begin
        next_st.flag = 1'b1;
        next_st.cnt  = '0;
      end else begin
        next_st.cnt = st.cnt + `FILT_W'(1);
      end
    end else begin
      if (!clearCond) begin
        next_st.cnt = '0;
      end else if (st.cnt == FILT_CYC) begin
        next_st.flag = 1'b0;
        next_st.cnt  = '0;
      end else begin
        next_st.cnt = st.cnt + `FILT_W'(1);
      end
    end
    if (!rst_n) begin
      next_st = '0;
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    st <= next_st;
  end

  assign flag = st.flag;

  //-----------------------------------------------------------------
  // checks
  //-----------------------------------------------------------------
  property p_setFiltered;
    @(posedge sys_clk) disable iff (!rst_n)
      $rose(st.flag) |-> $past(st.cnt) == FILT_CYC && $past(setCond);
  endproperty
  a_setFiltered: assert property (p_setFiltered) // [R14]
    else $error("flag set before filter time");

  property p_clearFiltered;
    @(posedge sys_clk) disable iff (!rst_n)
      $fell(st.flag) |-> $past(st.cnt) == FILT_CYC && $past(clearCond);
  endproperty
  a_clearFiltered: assert property (p_clearFiltered) // [R3]
    else $error("flag cleared before filter time");

endmodule : threshold_deglitch

// ===== src/reset_supervisor_fault_monitor.sv
// reset supervisor combining fault sources into an open-drain reset
`timescale 1ns/100ps
`include "reset_supervisor_regs.svh"
module reset_supervisor_fault_monitor
  import reset_supervisor_pkg::*;
#(
  parameter logic [`CNT_W-1:0] RELEASE_CYC =
    `CNT_W'(`NS_TO_CYC(`RELEASE_HOLD_TIME_NS)),
  parameter logic [`CNT_W-1:0] TURN_ON_CYC =
    `CNT_W'(`NS_TO_CYC(`TURN_ON_DELAY_NS)),
  parameter logic [`CNT_W-1:0] SS_LIMIT_CYC =
    `CNT_W'(`NS_TO_CYC(`SS_LIMIT_TIME_NS)),
  parameter logic [`FILT_W-1:0] FILT_CYC =
    `FILT_W'(`NS_TO_CYC(`FILTER_TIME_NS))
) (
  input  wire logic sys_clk,          // system clock
  input  wire logic rst_n,            // sync reset, active low
  input  wire logic fbBelowUv,        // feedback under uv trip level
  input  wire logic fbAboveUvHyst,    // feedback over uv level plus hyst
  input  wire logic fbAboveOv,        // feedback over ov trip level
  input  wire logic fbBelowOvHyst,    // feedback under ov level less hyst
  input  wire logic tempAboveTrip,    // junction over thermal trip temp
  input  wire logic tempBelowRecover, // junction under recover temp
  input  wire logic enableHigh,       // enable pin above threshold
  input  wire logic vccBelowLockout,  // supply under lockout less hyst
  input  wire logic vccAboveLockout,  // supply over lockout level
  input  wire logic outputAtTarget,   // output reached full voltage
  input  wire logic vinAboveMin,      // input high enough for reset
  output logic      resetOut,         // reset pin level when driven
  output logic      resetOe,          // reset pulldown enable
  output logic      switchStop,       // stop switching
  output logic      switchPulldown    // weak switch node pulldown
);

  monitor_s           st;
  monitor_s           next_st;
  logic [`SYNC_W-1:0] pins;
  logic               uvFlag;
  logic               ovFlag;
  logic               stopped;
  logic               hardFault;

  //-----------------------------------------------------------------
  // pin gathering and feedback filters
  //-----------------------------------------------------------------
  // asynchronous comparator levels into one vector
  always_comb begin
    pins                 = '0;
    pins[`PIN_FB_UV]     = fbBelowUv;
    pins[`PIN_FB_UV_OK]  = fbAboveUvHyst;
    pins[`PIN_FB_OV]     = fbAboveOv;
    pins[`PIN_FB_OV_OK]  = fbBelowOvHyst;
    pins[`PIN_TEMP_TRIP] = tempAboveTrip;
    pins[`PIN_TEMP_OK]   = tempBelowRecover;
    pins[`PIN_ENABLE]    = enableHigh;
    pins[`PIN_VCC_LOW]   = vccBelowLockout;
    pins[`PIN_VCC_OK]    = vccAboveLockout;
    pins[`PIN_TARGET]    = outputAtTarget;
    pins[`PIN_VIN_OK]    = vinAboveMin;
  end

  // [R3] undervoltage filter
  threshold_deglitch #(
    .FILT_CYC (FILT_CYC)
  ) uvFilter (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .setCond   (st.sync[`PIN_FB_UV]),
    .clearCond (st.sync[`PIN_FB_UV_OK]),
    .flag      (uvFlag)
  );

  // [R4] overvoltage filter
  threshold_deglitch #(
    .FILT_CYC (FILT_CYC)
  ) ovFilter (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .setCond   (st.sync[`PIN_FB_OV]),
    .clearCond (st.sync[`PIN_FB_OV_OK]),
    .flag      (ovFlag)
  );

  // converter not switching, and any fault that restarts the hold
  assign stopped   = st.thermal | st.vccFault | st.enFault;
  assign hardFault = stopped | uvFlag | ovFlag;

  //-----------------------------------------------------------------
  // next state
  //-----------------------------------------------------------------
  always_comb begin
    next_st = st;
    // two-flop synchroniser
    next_st.meta = pins;
    next_st.sync = st.meta;

    // [R6] thermal trip, set wins
    if (st.sync[`PIN_TEMP_TRIP]) begin
      next_st.thermal = 1'b1;
    end else if (st.sync[`PIN_TEMP_OK]) begin
      next_st.thermal = 1'b0;
    end

    // [R8] supply lockout, set wins
    if (st.sync[`PIN_VCC_LOW]) begin
      next_st.vccFault = 1'b1;
    end else if (st.sync[`PIN_VCC_OK]) begin
      next_st.vccFault = 1'b0;
    end

    // [R7] [R15] enable low then turn-on delay
    if (!st.sync[`PIN_ENABLE]) begin
      next_st.enFault = 1'b1;
      next_st.onCnt   = '0;
    end else if (st.enFault) begin
      if (st.onCnt == TURN_ON_CYC - `CNT_W'(1)) begin
        next_st.enFault = 1'b0;
      end else begin
        next_st.onCnt = st.onCnt + `CNT_W'(1);
      end
    end

    // [R9] soft-start lockout until target or limit
    if (stopped) begin
      next_st.ssActive = 1'b1;
      next_st.ssCnt    = '0;
    end else if (st.ssActive) begin
      if (st.sync[`PIN_TARGET] ||
          st.ssCnt == SS_LIMIT_CYC - `CNT_W'(1)) begin
        next_st.ssActive = 1'b0;
      end else begin
        next_st.ssCnt = st.ssCnt + `CNT_W'(1);
      end
    end

    // [R2] [R13] release hold restarts on any fault
    if (hardFault) begin
      next_st.holdActive = 1'b1;
      next_st.holdCnt    = '0;
    end else if (st.holdActive) begin
      if (st.holdCnt == RELEASE_CYC - `CNT_W'(1)) begin
        next_st.holdActive = 1'b0;
      end else begin
        next_st.holdCnt = st.holdCnt + `CNT_W'(1);
      end
    end

    // [R10] lockout alone needs no hold
    case (st.state)
      ST_FAULT: begin
        if (!hardFault) begin
          next_st.state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (hardFault) begin
          next_st.state = ST_FAULT;
        end else if (!st.holdActive) begin
          next_st.state = st.ssActive ? ST_LOCK : ST_OPEN;
        end
      end
      ST_LOCK: begin
        if (hardFault) begin
          next_st.state = ST_FAULT;
        end else if (!st.ssActive) begin
          next_st.state = ST_OPEN;
        end
      end
      ST_OPEN: begin
        if (hardFault) begin
          next_st.state = ST_FAULT;
        end else if (st.ssActive) begin
          next_st.state = ST_LOCK;
        end
      end
      default: begin
        next_st.state = ST_FAULT;
      end
    endcase

    // [R1] [R11] [R16] pulldown while any cause is active
    next_st.resetOut = 1'b0;
    next_st.resetOe  = st.sync[`PIN_VIN_OK] &
                       (hardFault | st.holdActive | st.ssActive);

    // [R5] overvoltage stops switching and pulls node down
    next_st.switchStop     = stopped | ovFlag;
    next_st.switchPulldown = ovFlag;

    // synchronous reset to safe state
    if (!rst_n) begin
      next_st            = '0;
      next_st.state      = ST_FAULT;
      next_st.enFault    = 1'b1;
      next_st.ssActive   = 1'b1;
      next_st.holdActive = 1'b1;
      next_st.switchStop = 1'b1;
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    st <= next_st;
  end

  // outputs straight from flops
  assign resetOut       = st.resetOut;
  assign resetOe        = st.resetOe;
  assign switchStop     = st.switchStop;
  assign switchPulldown = st.switchPulldown;

  //-----------------------------------------------------------------
  // checks
  //-----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_disabledLow;
    st.enFault && st.sync[`PIN_VIN_OK] |=> resetOe;
  endproperty
  a_disabledLow: assert property (p_disabledLow) // [R1]
    else $error("reset released while disabled");

  property p_enableLow;
    !st.sync[`PIN_ENABLE] |=> st.enFault && st.onCnt == '0;
  endproperty
  a_enableLow: assert property (p_enableLow) // [R7]
    else $error("enable low did not raise fault");

  property p_turnOn;
    $fell(st.enFault) |-> $past(st.onCnt) == TURN_ON_CYC - `CNT_W'(1);
  endproperty
  a_turnOn: assert property (p_turnOn) // [R15]
    else $error("turn-on delay length wrong");

  property p_holdLength;
    $fell(st.holdActive) |->
      $past(st.holdCnt) == RELEASE_CYC - `CNT_W'(1) && !$past(hardFault);
  endproperty
  a_holdLength: assert property (p_holdLength) // [R13]
    else $error("release hold length wrong");

  property p_holdRestart;
    hardFault |=> st.holdActive && st.holdCnt == '0 ##1 resetOe || !rst_n
      || !$past(st.sync[`PIN_VIN_OK]);
  endproperty
  a_holdRestart: assert property (p_holdRestart) // [R2]
    else $error("fault did not restart hold");

  property p_overvoltage;
    ovFlag |=> switchStop && switchPulldown;
  endproperty
  a_overvoltage: assert property (p_overvoltage) // [R5]
    else $error("overvoltage did not stop switching");

  property p_thermal;
    st.sync[`PIN_TEMP_TRIP] |=> st.thermal ##1 switchStop;
  endproperty
  a_thermal: assert property (p_thermal) // [R6]
    else $error("thermal trip not flagged");

  property p_supply;
    st.sync[`PIN_VCC_LOW] |=> st.vccFault;
  endproperty
  a_supply: assert property (p_supply) // [R8]
    else $error("supply lockout not flagged");

  property p_ssLimit;
    st.ssActive && !stopped && st.ssCnt == SS_LIMIT_CYC - `CNT_W'(1)
      |=> !st.ssActive;
  endproperty
  a_ssLimit: assert property (p_ssLimit) // [R9]
    else $error("soft-start limit not honoured");

  property p_ssNoHold;
    $fell(st.ssActive) && !hardFault && !st.holdActive |=> !resetOe;
  endproperty
  a_ssNoHold: assert property (p_ssNoHold) // [R10]
    else $error("lockout end did not release reset");

  property p_lowInput;
    !st.sync[`PIN_VIN_OK] |=> !resetOe;
  endproperty
  a_lowInput: assert property (p_lowInput) // [R11]
    else $error("reset driven below minimum input");

  c_release:   cover property ($fell(resetOe));
  c_ovEvent:   cover property ($rose(ovFlag) ##[1:20] switchPulldown);
  c_ssTimeout: cover property (st.ssActive && !stopped
                               && st.ssCnt == SS_LIMIT_CYC - `CNT_W'(1));
  c_lockOnly:  cover property (st.state == ST_LOCK ##1 st.state == ST_OPEN);

endmodule : reset_supervisor_fault_monitor

// ===== verif/reset_consumer_model.sv
// system logic model that consumes the open-drain reset line
`timescale 1ns/100ps
module reset_consumer_model (
  input  wire logic enReq,      // bench asks for the converter to run
  input  wire logic resetOe,    // pulldown enable from the supervisor
  input  wire logic resetOut,   // level driven while pulled down
  output logic      enableHigh, // enable pin level to the supervisor
  output logic      sysRunning  // reset line seen released
);
  // enable driven low to shut down
  assign enableHigh = enReq;
  // pull-up holds the line high while the pulldown is off
  assign sysRunning = resetOe ? resetOut : 1'b1;
endmodule : reset_consumer_model

// ===== verif/tb.sv
// self-checking bench for the reset supervisor fault monitor
`timescale 1ns/100ps
`include "reset_supervisor_regs.svh"
module tb;
  import reset_supervisor_pkg::*;
  // short counts keep the run brief
  localparam int REL = 20;
  localparam int TON = 10;
  localparam int SSL = 40;
  localparam int FLT = 4;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       enReq = 1'b0;
  logic [3:0] setV = 4'h0;   // uv, ov, thermal, supply set inputs
  logic [3:0] clrV = 4'hf;   // matching clear inputs
  logic       outputAtTarget = 1'b1;
  logic       vinAboveMin = 1'b1;
  logic       enableHigh, sysRunning;
  logic       resetOut, resetOe, switchStop, switchPulldown;
  int         fails = 0;
  int         n_tests = 0;
  int         n;

  // half period of 12.5 ns gives 40 MHz
  always #12.5 sys_clk = ~sys_clk;

  // ---------------------------------------------------------------
  // design and partner
  // ---------------------------------------------------------------
  reset_supervisor_fault_monitor #(
    .RELEASE_CYC  (`CNT_W'(REL)),
    .TURN_ON_CYC  (`CNT_W'(TON)),
    .SS_LIMIT_CYC (`CNT_W'(SSL)),
    .FILT_CYC     (`FILT_W'(FLT))
  ) u_reset_supervisor_fault_monitor (
    .sys_clk          (sys_clk),
    .rst_n            (rst_n),
    .fbBelowUv        (setV[0]),
    .fbAboveUvHyst    (clrV[0]),
    .fbAboveOv        (setV[1]),
    .fbBelowOvHyst    (clrV[1]),
    .tempAboveTrip    (setV[2]),
    .tempBelowRecover (clrV[2]),
    .enableHigh       (enableHigh),
    .vccBelowLockout  (setV[3]),
    .vccAboveLockout  (clrV[3]),
    .outputAtTarget   (outputAtTarget),
    .vinAboveMin      (vinAboveMin),
    .resetOut         (resetOut),
    .resetOe          (resetOe),
    .switchStop       (switchStop),
    .switchPulldown   (switchPulldown)
  );

  reset_consumer_model u_reset_consumer_model (
    .enReq      (enReq),
    .resetOe    (resetOe),
    .resetOut   (resetOut),
    .enableHigh (enableHigh),
    .sysRunning (sysRunning)
  );

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  // k cycles, then a fixed skew off the edge
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #2;
  endtask : step

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check

  // counts cycles until the pulldown enable reaches a level
  task automatic wait_oe(input logic v, input int lim, output int c);
    c = 0;
    while (resetOe !== v && c < lim) begin
      step(1);
      c++;
    end
  endtask : wait_oe

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // disabled converter, then release after turn-on and hold
  task automatic t_enable;
    enReq = 1'b0;
    step(10);
    check("oeDisabled", resetOe, 1'b1);
    check("lineDisabled", sysRunning, 1'b0);
    check("stopDisabled", switchStop, 1'b1);
    enReq = 1'b1;
    wait_oe(1'b0, 200, n);
    check("onDelay", n >= TON + REL && n <= TON + REL + 10, 1'b1);
    check("stopRun", switchStop, 1'b0);
    check("pinLevel", resetOut, 1'b0);
  endtask : t_enable

  // soft start lockout ends on target or on limit
  task automatic t_softstart;
    outputAtTarget = 1'b0;
    enReq = 1'b0;
    step(6);
    enReq = 1'b1;
    step(TON + REL + 8);
    check("ssLock", resetOe, 1'b1);
    outputAtTarget = 1'b1;
    wait_oe(1'b0, 10, n);
    check("ssNoHold", n <= 4, 1'b1);
    outputAtTarget = 1'b0;
    enReq = 1'b0;
    step(6);
    enReq = 1'b1;
    wait_oe(1'b0, 300, n);
    check("ssLimit", n >= TON + SSL && n <= TON + SSL + 10, 1'b1);
    outputAtTarget = 1'b1;
  endtask : t_softstart

  // pulses no longer than the filter leave reset released
  task automatic t_glitch(input int i);
    int hits;
    hits = 0;
    setV[i] = 1'b1;
    clrV[i] = 1'b0;
    step(FLT);
    setV[i] = 1'b0;
    clrV[i] = 1'b1;
    repeat (12) begin
      step(1);
      if (resetOe !== 1'b0) hits++;
    end
    check("glitch", hits, 0);
  endtask : t_glitch

  // set, hysteresis gap, clear, then the hold time
  task automatic t_fault(input int i);
    setV[i] = 1'b1;
    clrV[i] = 1'b0;
    wait_oe(1'b1, FLT + 8, n);
    check("faultSet", resetOe, 1'b1);
    if (i == 1) begin
      check("ovStop", switchStop, 1'b1);
      check("ovPull", switchPulldown, 1'b1);
    end
    setV[i] = 1'b0;
    step(30);
    check("hystGap", resetOe, 1'b1);
    clrV[i] = 1'b1;
    wait_oe(1'b0, REL + FLT + 12, n);
    check("holdTime", n >= REL && resetOe === 1'b0, 1'b1);
    check("pullOff", switchPulldown, 1'b0);
  endtask : t_fault

  // low input lets the reset line float
  task automatic t_vin;
    enReq = 1'b0;
    step(8);
    vinAboveMin = 1'b0;
    step(6);
    check("vinFloat", resetOe, 1'b0);
    check("vinLine", sysRunning, 1'b1);
    vinAboveMin = 1'b1;
    enReq = 1'b1;
    wait_oe(1'b1, 8, n);
    check("vinRearm", resetOe, 1'b1);
    wait_oe(1'b0, 200, n);
    check("vinBack", n >= REL && resetOe === 1'b0, 1'b1);
  endtask : t_vin

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    step(12);
    rst_n = 1'b1;
    t_enable();
    t_softstart();
    t_glitch(0);
    t_glitch(1);
    for (int i = 0; i < 4; i++) begin
      t_fault(i);
    end
    t_vin();
    wrap_up();
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    wrap_up();
  end
endmodule : tb
